//--- hw/synth_ratio_and_enable_regs.sv
// Synthesizer 1 FEC ratio and synthesizer output enable register bank
//
// Function
// - The ratio register holds the denominator in bits 15:0 and the numerator in 31:16.
// - Synthesizer 1 frequency equals base frequency x multiplier x 16 x numerator / denominator.
// - Enable bit 0 gates the synthesizer 0 output.
// - Enable bit 1 gates the synthesizer 1 output, and both are on after reset.
// - The base frequency field is an unsigned 16-bit value in hertz.
`timescale 1ns/100ps
`default_nettype none
`include "synth_regs_cfg.svh"
module synth_ratio_and_enable_regs
  import synth_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire synth_regs_pkg::reg_addr_t cfg_addr,
  input wire synth_regs_pkg::reg_byte_t cfg_wdata,
  input wire synth_regs_pkg::ratio_half_t base_frequency,
  input wire synth_regs_pkg::ratio_half_t base_multiplier,
  output var synth_regs_pkg::reg_byte_t cfg_rdata,
  output var synth_regs_pkg::ratio_half_t fec_numerator,
  output var synth_regs_pkg::ratio_half_t fec_denominator,
  output logic synth0_out_en,
  output logic synth1_out_en,
  output var synth_regs_pkg::freq_t synth_one_freq_hz,
  output logic synth_one_freq_valid
);
  import synth_regs_pkg::*;

  // Byte-wide port; the 32-bit ratio spans four consecutive addresses, low byte first
  // Each byte lands on its own, so a partial update is visible until the last byte
  logic [`RATIO_MSB:0] synth_one_fec_ratio;
  logic [`RATIO_MSB:0] next_synth_one_fec_ratio;
  logic [`ENABLE_BITS-1:0] synth_output_enables;
  logic [`ENABLE_BITS-1:0] next_synth_output_enables;
  reg_byte_t next_cfg_rdata;
  ratio_half_t next_fec_numerator;
  ratio_half_t next_fec_denominator;
  logic next_synth0_out_en;
  logic next_synth1_out_en;
  freq_t next_freq;
  logic next_freq_valid;
  logic [`BYTE_SEL_MSB:0] byte_sel;
  logic ratio_hit;
  logic enable_hit;

  assign byte_sel = cfg_addr[`BYTE_SEL_MSB:0];

  // Address decode kept apart so reads and writes share one comparison
  always_comb
  begin
    ratio_hit = 1'b0;
    enable_hit = 1'b0;
    if (cfg_addr >= `RATIO_ADDR_LO && cfg_addr <= `RATIO_ADDR_HI)
    begin
      ratio_hit = 1'b1;
    end
    else if (cfg_addr == `ENABLE_ADDR)
    begin
      enable_hit = 1'b1;
    end
  end

  // A read in the same cycle as a write returns the old contents
  always_comb
  begin
    next_synth_one_fec_ratio = synth_one_fec_ratio;
    next_synth_output_enables = synth_output_enables;
    next_cfg_rdata = cfg_rdata;
    if (cfg_wr && ratio_hit)
    begin
      next_synth_one_fec_ratio[byte_sel*`BYTE_BITS +: `BYTE_BITS] = cfg_wdata;
    end
    else if (cfg_wr && enable_hit)
    begin
      // Reserved bits are not stored at all, so no write can ever set them
      next_synth_output_enables = cfg_wdata[`ENABLE_BITS-1:0];
    end
    if (cfg_rd && ratio_hit)
    begin
      next_cfg_rdata = synth_one_fec_ratio[byte_sel*`BYTE_BITS +: `BYTE_BITS];
    end
    else if (cfg_rd && enable_hit)
    begin
      next_cfg_rdata = {`RESERVED_ZERO, synth_output_enables};
    end
    else if (cfg_rd)
    begin
      next_cfg_rdata = `RDATA_RESET;
    end
  end

  // Field and enable outputs trail the registers by one cycle so every output is a flop
  always_comb
  begin
    next_fec_numerator = synth_one_fec_ratio[`RATIO_MSB:`NUMER_LSB];
    next_fec_denominator = synth_one_fec_ratio[`NUMER_LSB-1:`DENOM_LSB];
    next_synth0_out_en = synth_output_enables[`SYNTH0_EN_BIT];
    next_synth1_out_en = synth_output_enables[`SYNTH1_EN_BIT];
  end

  // Frequency per the synthesis formula; a zero denominator yields no valid result
  // Division truncates; the 64-bit result holds any 16-bit inputs, so it never overflows
  always_comb
  begin
    next_freq_valid = (synth_one_fec_ratio[`NUMER_LSB-1:`DENOM_LSB] != `ZERO_HALF);
    next_freq = `FREQ_RESET;
    if (next_freq_valid)
    begin
      next_freq = (64'(base_frequency) * 64'(base_multiplier) * 64'(`SYNTH_SCALE)
        * 64'(synth_one_fec_ratio[`RATIO_MSB:`NUMER_LSB]))
        / 64'(synth_one_fec_ratio[`NUMER_LSB-1:`DENOM_LSB]);
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      synth_one_fec_ratio <= `RATIO_RESET;
      synth_output_enables <= `ENABLE_BITS'(`ENABLE_RESET);
      cfg_rdata <= `RDATA_RESET;
      fec_numerator <= `NUMER_RESET;
      fec_denominator <= `DENOM_RESET;
      synth0_out_en <= `SYNTH_EN_RESET;
      synth1_out_en <= `SYNTH_EN_RESET;
      synth_one_freq_hz <= `FREQ_RESET;
      synth_one_freq_valid <= 1'b0;
    end
    else
    begin
      synth_one_fec_ratio <= next_synth_one_fec_ratio;
      synth_output_enables <= next_synth_output_enables;
      cfg_rdata <= next_cfg_rdata;
      fec_numerator <= next_fec_numerator;
      fec_denominator <= next_fec_denominator;
      synth0_out_en <= next_synth0_out_en;
      synth1_out_en <= next_synth1_out_en;
      synth_one_freq_hz <= next_freq;
      synth_one_freq_valid <= next_freq_valid;
    end
  end

  property p_ratio_write;
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `RATIO_ADDR_LO) |=> ##1 (fec_denominator[7:0] == $past(cfg_wdata, 2));
  endproperty
  a_ratio_write: assert property (p_ratio_write) else $error("denominator low byte not stored");

  property p_numer_write;
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `RATIO_ADDR_HI) |=> ##1 (fec_numerator[15:8] == $past(cfg_wdata, 2));
  endproperty
  a_numer_write: assert property (p_numer_write) else $error("numerator high byte not stored");

  property p_denom_hi_write;
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `RATIO_ADDR_LO + 8'h01) |=> ##1
      (fec_denominator[15:8] == $past(cfg_wdata, 2));
  endproperty
  a_denom_hi_write: assert property (p_denom_hi_write) else $error("denominator high byte lost");

  property p_numer_lo_write;
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `RATIO_ADDR_LO + 8'h02) |=> ##1
      (fec_numerator[7:0] == $past(cfg_wdata, 2));
  endproperty
  a_numer_lo_write: assert property (p_numer_lo_write) else $error("numerator low byte lost");

  // Frequency and fields come from the same register snapshot, base inputs one cycle back
  property p_freq;
    @(posedge mclk) disable iff (!resetn)
    synth_one_freq_valid |-> (synth_one_freq_hz == (64'($past(base_frequency))
      * 64'($past(base_multiplier)) * 64'(`SYNTH_SCALE) * 64'(fec_numerator))
      / 64'(fec_denominator));
  endproperty
  a_freq: assert property (p_freq) else $error("frequency differs from formula");

  property p_zero_denom;
    @(posedge mclk) disable iff (!resetn)
    (fec_denominator == `ZERO_HALF) |-> !synth_one_freq_valid;
  endproperty
  a_zero_denom: assert property (p_zero_denom) else $error("valid with zero denominator");

  property p_en0;
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `ENABLE_ADDR) |=> ##1 (synth0_out_en == $past(cfg_wdata[0], 2));
  endproperty
  a_en0: assert property (p_en0) else $error("synth0 enable wrong");

  property p_en1;
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `ENABLE_ADDR) |=> ##1 (synth1_out_en == $past(cfg_wdata[1], 2));
  endproperty
  a_en1: assert property (p_en1) else $error("synth1 enable wrong");

  property p_reserved;
    @(posedge mclk) disable iff (!resetn)
    (cfg_rd && cfg_addr == `ENABLE_ADDR) |=> (cfg_rdata[7:2] == 6'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_unmapped;
    @(posedge mclk) disable iff (!resetn)
    (cfg_rd && cfg_addr == `UNMAPPED_ADDR) |=> (cfg_rdata == `RDATA_RESET);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  property p_enable_read;
    @(posedge mclk) disable iff (!resetn)
    (cfg_rd && !cfg_wr && cfg_addr == `ENABLE_ADDR) |=>
      (cfg_rdata[1:0] == {synth1_out_en, synth0_out_en});
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable readback wrong");

  // Read data must hold between reads so a slow host can pick it up late
  property p_rdata_hold;
    @(posedge mclk) disable iff (!resetn)
    !cfg_rd |=> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

  property p_readback;
    @(posedge mclk) disable iff (!resetn)
    (cfg_rd && !cfg_wr && cfg_addr == `RATIO_ADDR_LO) |=> (cfg_rdata == fec_denominator[7:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("ratio readback wrong");
endmodule
`default_nettype wire

//--- hw/synth_regs_cfg.svh
// Register map constants for the synthesizer ratio and enable bank
`ifndef SYNTH_REGS_CFG_SVH
`define SYNTH_REGS_CFG_SVH
`define RATIO_ADDR_LO 8'h5C
`define RATIO_ADDR_HI 8'h5F
`define ENABLE_ADDR 8'h71
`define RATIO_RESET 32'h00010001
`define ENABLE_RESET 8'h03
`define DENOM_LSB 0
`define NUMER_LSB 16
`define ENABLE_BITS 2
`define SYNTH_SCALE 16
`define RATIO_MSB 31
`define BYTE_BITS 8
`define BYTE_SEL_MSB 1
`define UNMAPPED_ADDR 8'h70
`define NUMER_RESET 16'h0001
`define DENOM_RESET 16'h0001
`define SYNTH_EN_RESET 1'b1
`define SYNTH0_EN_BIT 0
`define SYNTH1_EN_BIT 1
`define RDATA_RESET 8'h00
`define RESERVED_ZERO 6'h00
`define ZERO_HALF 16'h0000
`define FREQ_RESET 64'h0
`endif

//--- hw/synth_regs_pkg.sv
// Types shared by the synthesizer register bank
package synth_regs_pkg;
  typedef logic [7:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [15:0] ratio_half_t;
  typedef logic [63:0] freq_t;
endpackage

//--- verification/cfg_host.sv
// Host model that drives byte transfers on the configuration port
`timescale 1ns/100ps
`default_nettype none
module cfg_host
  import synth_regs_pkg::*;
(
  input wire logic mclk,
  output logic cfg_wr = 1'b0,
  output logic cfg_rd = 1'b0,
  output var synth_regs_pkg::reg_addr_t cfg_addr = 8'h00,
  output var synth_regs_pkg::reg_byte_t cfg_wdata = 8'h00
);
  // Released address and data lines show the inverse and both strobes go low, so a stale value never looks driven
  task automatic xfer(input logic w, input reg_addr_t a, input reg_byte_t v);
    @(posedge mclk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {w, !w, a, v};
    @(posedge mclk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {2'b00, ~a, ~v};
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking testbench for the synthesizer ratio and enable bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import synth_regs_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, wr, rd, en0, en1, valid;
  reg_addr_t addr;
  reg_byte_t wdata, rdata;
  ratio_half_t bf = 16'h0000, bm = 16'h0000, num, den;
  freq_t hz;
  int fail_count = 0, n_compared = 0;
  always #5 mclk = ~mclk;
  cfg_host cfg_host_i(.mclk(mclk), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_wdata(wdata));
  synth_ratio_and_enable_regs synth_ratio_and_enable_regs_i(.mclk(mclk), .resetn(resetn),
    .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_wdata(wdata), .base_frequency(bf),
    .base_multiplier(bm), .cfg_rdata(rdata), .fec_numerator(num), .fec_denominator(den),
    .synth0_out_en(en0), .synth1_out_en(en1), .synth_one_freq_hz(hz),
    .synth_one_freq_valid(valid));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    fail_count += int'(g !== e);
    if (g !== e)
      $display("unexpected %s expected %0h seen %0h", n, e, g);
  endtask
  // Reset values first, then bits 7:2 are set to show they are dropped
  task automatic test_enables;
    chk("reset fields", {32'h00010001, 2'b11}, {num, den, en1, en0});
    cfg_host_i.xfer(1'b0, 8'h5E, 8'h00);
    #1 chk("ratio byte 2", 8'h01, rdata);
    cfg_host_i.xfer(1'b1, 8'h71, 8'hFD);
    #41 chk("enables", 2'b01, {en1, en0});
    cfg_host_i.xfer(1'b0, 8'h71, 8'h00);
    #1 chk("enable byte", 8'h01, rdata);
    cfg_host_i.xfer(1'b0, 8'h70, 8'h00);
    #1 chk("unmapped byte", 8'h00, rdata);
    $display("test_enables done");
  endtask
  // Bytes land one by one, so only the final frequency is judged
  task automatic test_ratio;
    @(posedge mclk);
    {bf, bm} <= {16'h9C40, 16'h0798};
    for (int k = 0; k < 4; k++)
      cfg_host_i.xfer(1'b1, 8'h5C + 8'(k), 8'(32'h00FF00ED >> (8 * k)));
    #41 chk("ratio fields", 32'h00FF00ED, {num, den});
    chk("freq", 64'd40000 * 1944 * 16 * 255 / 237, hz);
    chk("freq valid", 1'b1, valid);
    $display("test_ratio done");
  endtask
  // A zero denominator must give no frequency rather than a divide fault
  task automatic test_zero_den;
    cfg_host_i.xfer(1'b1, 8'h5C, 8'h00);
    cfg_host_i.xfer(1'b1, 8'h5D, 8'h00);
    #41 chk("zero den valid", 1'b0, valid);
    chk("zero den freq", 64'h0, hz);
    $display("test_zero_den done");
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #5000;
    fail_count++;
    results;
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    test_enables;
    test_ratio;
    test_zero_den;
    results;
  end
endmodule
`default_nettype wire
